// *** logic/cta_pkg.sv ***
// Purpose: shared types and constants of the cycle-timed alu datapath
// Assumes: one system clock; all timing counted in whole clocks
// Notes: request and result travel as packed structs
//
// Behaviour
// - external-data moves reach on-chip or off-chip expansion ram or program flash
// - add, addc, subb with register source: one byte, one cycle
// - add, addc, subb with direct source: two bytes, two cycles
// - add, addc, subb with indirect source: one byte, two cycles
// - add, addc, subb with immediate source: two bytes, two cycles
// - and/or/xor into A: reg 1/1, indirect 1/2, direct or immediate 2/2
// - and/or/xor of A into a direct byte: two bytes, two cycles
// - and/or/xor of immediate into a direct byte: three bytes, three cycles
// - accumulator-only operations: one byte, one cycle
// - A/register moves 1/1; loads from direct or immediate 2/2
// - moving A or a register to a direct byte: two bytes, two cycles
// - direct-to-direct move: three bytes, three cycles
// - loading A from indirect ram: one byte, two cycles
// - timing counts system clocks only, no machine-cycle grouping
// - no instruction exceeds eight clocks; divide is the longest at eight
`default_nettype none

package cta_pkg;
   typedef logic [7:0] cta_byte_t;
   typedef logic [15:0] cta_addr_t;
   typedef logic [1:0] cta_len_t;
   typedef logic [3:0] cta_cyc_t;

   localparam cta_len_t CTA_LEN_ONE = 2'h1;
   localparam cta_len_t CTA_LEN_TWO = 2'h2;
   localparam cta_len_t CTA_LEN_THREE = 2'h3;
   localparam cta_cyc_t CTA_CYC_ONE = 4'h1;
   localparam cta_cyc_t CTA_CYC_TWO = 4'h2;
   localparam cta_cyc_t CTA_CYC_THREE = 4'h3;
   localparam cta_cyc_t CTA_CYC_MOVX = 4'h3;
   localparam cta_cyc_t CTA_CYC_MUL = 4'h4;
   localparam cta_cyc_t CTA_CYC_DIV = 4'h8;
   localparam cta_cyc_t CTA_CYC_MAX = 4'h8;
   localparam cta_cyc_t CTA_CNT_ZERO = 4'h0;
   localparam cta_cyc_t CTA_CNT_STEP = 4'h1;
   localparam cta_addr_t CTA_EXPANSION_DATA_RAM_ONCHIP_TOP = 16'h0FFF;
   localparam cta_byte_t CTA_BYTE_ZERO = 8'h00;
   localparam cta_byte_t CTA_BYTE_ONE = 8'h01;
   localparam logic [3:0] CTA_BCD_MAX = 4'h9;
   localparam logic [8:0] CTA_DA_LO = 9'h006;
   localparam logic [8:0] CTA_DA_HI = 9'h060;
   localparam logic [8:0] CTA_DA_NONE = 9'h000;

   typedef enum logic [4:0] {
      CTA_OP_ADD, CTA_OP_ADDC, CTA_OP_SUBB, CTA_OP_ANL, CTA_OP_ORL,
      CTA_OP_XRL, CTA_OP_CLR, CTA_OP_CPL, CTA_OP_RL, CTA_OP_RLC,
      CTA_OP_RR, CTA_OP_RRC, CTA_OP_SWAP, CTA_OP_DA, CTA_OP_MOV,
      CTA_OP_INC, CTA_OP_DEC, CTA_OP_MUL, CTA_OP_DIV, CTA_OP_MOVX
   } cta_op_t;

   // operand source / destination shape
   typedef enum logic [2:0] {
      CTA_AM_ACC, CTA_AM_REG, CTA_AM_DIRECT, CTA_AM_INDIRECT,
      CTA_AM_IMM, CTA_AM_DIR_ACC, CTA_AM_DIR_IMM, CTA_AM_DIR_DIR
   } cta_mode_t;

   typedef enum logic [1:0] {
      CTA_TGT_ONCHIP, CTA_TGT_OFFCHIP, CTA_TGT_FLASH
   } cta_tgt_t;

   typedef struct packed {
      logic cy;
      logic ac;
      logic ov;
      logic p;
   } cta_flags_t;

   typedef struct packed {
      cta_op_t op;
      cta_mode_t mode;
      logic to_mem;
      logic flash_sel;
      cta_addr_t addr;
      cta_byte_t acc;
      cta_byte_t b;
      cta_byte_t src;
      cta_byte_t imm;
      cta_flags_t flags;
   } cta_req_t;

   typedef struct packed {
      cta_byte_t data;
      cta_byte_t b;
      logic wr_acc;
      logic wr_mem;
      logic wr_b;
      cta_flags_t flags;
      cta_tgt_t tgt;
      cta_len_t bytes;
      cta_cyc_t cycles;
   } cta_res_t;
endpackage

`default_nettype wire

// *** logic/cta_alu.sv ***
// Purpose: combinational arithmetic and logic core
// Assumes: operands already selected by the sequencer
// Notes: parity is left to the caller, it depends on the final A
`timescale 1ns/100ps
`default_nettype none

module cta_alu (
   // operation and operands
   input wire cta_pkg::cta_op_t op_i,
   input wire cta_pkg::cta_byte_t a_i,
   input wire cta_pkg::cta_byte_t b_i,
   input wire cta_pkg::cta_byte_t breg_i,
   input wire cta_pkg::cta_flags_t flags_i,
   // results
   output cta_pkg::cta_byte_t res_o,
   output cta_pkg::cta_byte_t resb_o,
   output cta_pkg::cta_flags_t flags_o
);
   import cta_pkg::*;

   // plain add ignores the incoming carry
   wire logic cin = (op_i == CTA_OP_ADD) ? 1'b0 : flags_i.cy;
   wire logic [8:0] add9 = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
   wire logic [4:0] addlo = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
   wire logic [7:0] add7 = {1'b0, a_i[6:0]} + {1'b0, b_i[6:0]} + {7'h00, cin};
   wire logic [8:0] sub9 = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
   wire logic [4:0] sublo = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin};
   wire logic [7:0] sub7 = {1'b0, a_i[6:0]} - {1'b0, b_i[6:0]} - {7'h00, cin};
   wire logic da_lo = (a_i[3:0] > CTA_BCD_MAX) || flags_i.ac;
   wire logic [8:0] da1 = {1'b0, a_i} + (da_lo ? CTA_DA_LO : CTA_DA_NONE);
   wire logic da_hi = (da1[7:4] > CTA_BCD_MAX) || da1[8] || flags_i.cy;
   wire logic [8:0] da2 = {1'b0, da1[7:0]} + (da_hi ? CTA_DA_HI : CTA_DA_NONE);
   wire logic [15:0] prod = {8'h00, a_i} * {8'h00, breg_i};
   wire logic divz = (breg_i == CTA_BYTE_ZERO);
   wire cta_byte_t quot = divz ? a_i : a_i / breg_i;
   wire cta_byte_t rem = divz ? breg_i : a_i % breg_i;

   always_comb begin
      res_o = b_i;
      resb_o = breg_i;
      flags_o = flags_i;
      case (op_i)
         CTA_OP_ADD, CTA_OP_ADDC: begin
            res_o = add9[7:0];
            flags_o.cy = add9[8];
            flags_o.ac = addlo[4];
            flags_o.ov = add7[7] ^ add9[8];
         end
         CTA_OP_SUBB: begin
            res_o = sub9[7:0];
            flags_o.cy = sub9[8];
            flags_o.ac = sublo[4];
            flags_o.ov = sub7[7] ^ sub9[8];
         end
         CTA_OP_ANL: res_o = a_i & b_i;
         CTA_OP_ORL: res_o = a_i | b_i;
         CTA_OP_XRL: res_o = a_i ^ b_i;
         CTA_OP_CLR: res_o = CTA_BYTE_ZERO;
         CTA_OP_CPL: res_o = ~a_i;
         CTA_OP_RL: res_o = {a_i[6:0], a_i[7]};
         CTA_OP_RR: res_o = {a_i[0], a_i[7:1]};
         CTA_OP_RLC: begin
            res_o = {a_i[6:0], flags_i.cy};
            flags_o.cy = a_i[7];
         end
         CTA_OP_RRC: begin
            res_o = {flags_i.cy, a_i[7:1]};
            flags_o.cy = a_i[0];
         end
         CTA_OP_SWAP: res_o = {a_i[3:0], a_i[7:4]};
         CTA_OP_DA: begin
            res_o = da2[7:0];
            flags_o.cy = flags_i.cy | da1[8] | da2[8];
         end
         CTA_OP_INC: res_o = a_i + CTA_BYTE_ONE;
         CTA_OP_DEC: res_o = a_i - CTA_BYTE_ONE;
         CTA_OP_MUL: begin
            res_o = prod[7:0];
            resb_o = prod[15:8];
            flags_o.cy = 1'b0;
            flags_o.ov = |prod[15:8];
         end
         CTA_OP_DIV: begin
            res_o = quot;
            resb_o = rem;
            flags_o.cy = 1'b0;
            flags_o.ov = divz;
         end
         default: res_o = b_i;
      endcase
   end
endmodule // cta_alu

`default_nettype wire

// *** logic/cta_exec.sv ***
// Purpose: issues one instruction at a time and holds it for its clock count
// Assumes: operands arrive with the request; caller performs the write-back
// Notes: a new request may be taken in the last cycle of the previous one
`timescale 1ns/100ps
`default_nettype none

module cta_exec (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // request
   input wire logic start_i,
   input wire cta_pkg::cta_req_t req_i,
   output logic ready_o,
   // result
   output logic busy_o,
   output logic done_o,
   output cta_pkg::cta_res_t res_o
);
   import cta_pkg::*;

   typedef enum logic {ST_IDLE, ST_EXEC} cta_state_t;

   function automatic logic cta_acc_only(cta_op_t op);
      logic r;
      r = 1'b0;
      case (op)
         CTA_OP_CLR, CTA_OP_CPL, CTA_OP_RL, CTA_OP_RLC,
         CTA_OP_RR, CTA_OP_RRC, CTA_OP_SWAP, CTA_OP_DA: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // clock count from opcode class and operand shape
   function automatic cta_cyc_t cta_cycles(cta_op_t op, cta_mode_t mode);
      cta_cyc_t c;
      c = CTA_CYC_ONE;
      if (op == CTA_OP_MUL) begin
         c = CTA_CYC_MUL;
      end else if (op == CTA_OP_DIV) begin
         c = CTA_CYC_DIV;
      end else if (op == CTA_OP_MOVX) begin
         c = CTA_CYC_MOVX;
      end else if (cta_acc_only(op)) begin
         c = CTA_CYC_ONE;
      end else begin
         case (mode)
            CTA_AM_ACC, CTA_AM_REG: c = CTA_CYC_ONE;
            CTA_AM_DIRECT: c = CTA_CYC_TWO;
            CTA_AM_INDIRECT: c = CTA_CYC_TWO;
            CTA_AM_IMM: c = CTA_CYC_TWO;
            CTA_AM_DIR_ACC: c = CTA_CYC_TWO;
            CTA_AM_DIR_IMM: c = CTA_CYC_THREE;
            CTA_AM_DIR_DIR: c = CTA_CYC_THREE;
            default: c = CTA_CYC_TWO;
         endcase
      end
      return c;
   endfunction

   function automatic cta_len_t cta_bytes(cta_op_t op, cta_mode_t mode);
      cta_len_t n;
      n = CTA_LEN_ONE;
      if (cta_acc_only(op) || op == CTA_OP_MUL || op == CTA_OP_DIV || op == CTA_OP_MOVX) begin
         n = CTA_LEN_ONE;
      end else begin
         case (mode)
            CTA_AM_ACC, CTA_AM_REG: n = CTA_LEN_ONE;
            CTA_AM_INDIRECT: n = CTA_LEN_ONE;
            CTA_AM_DIR_IMM, CTA_AM_DIR_DIR: n = CTA_LEN_THREE;
            default: n = CTA_LEN_TWO;
         endcase
      end
      return n;
   endfunction

   cta_state_t state_q, state_d;
   cta_req_t req_q;
   cta_cyc_t cnt_q, cnt_d;
   cta_res_t res_q, res_d;
   cta_cyc_t run_q;
   logic ready_q, ready_d;
   logic busy_q;
   logic done_q;

   // issue control; every count is in system clocks
   wire cta_cyc_t cyc_w = cta_cycles(req_i.op, req_i.mode);
   wire logic accept_w = start_i && ready_q;
   wire logic last_w = (state_q == ST_EXEC) && (cnt_q == CTA_CNT_ZERO);
   wire logic step_w = (state_q == ST_EXEC) && (cnt_q != CTA_CNT_ZERO);

   assign state_d = accept_w ? ST_EXEC : (last_w ? ST_IDLE : state_q);
   assign cnt_d = accept_w ? cyc_w - CTA_CNT_STEP : (step_w ? cnt_q - CTA_CNT_STEP : cnt_q);
   assign ready_d = (state_d == ST_IDLE) || (cnt_d == CTA_CNT_ZERO);

   // operand steering
   wire cta_op_t op_w = req_q.op;
   wire cta_mode_t mode_w = req_q.mode;
   wire logic incdec_w = (op_w == CTA_OP_INC) || (op_w == CTA_OP_DEC);
   wire logic logic_w = (op_w == CTA_OP_ANL) || (op_w == CTA_OP_ORL) || (op_w == CTA_OP_XRL);
   wire logic dir_dest_w = logic_w && (mode_w == CTA_AM_DIR_ACC || mode_w == CTA_AM_DIR_IMM);
   wire logic mem_dest_w = incdec_w && (mode_w != CTA_AM_ACC);
   wire logic mov_w = (op_w == CTA_OP_MOV);
   wire logic movx_w = (op_w == CTA_OP_MOVX);
   wire logic imm_src_w = (mode_w == CTA_AM_IMM) || (mode_w == CTA_AM_DIR_IMM);
   wire logic acc_src_w = (mode_w == CTA_AM_DIR_ACC)
      || (mov_w && req_q.to_mem && mode_w == CTA_AM_REG)
      || (movx_w && req_q.to_mem);
   wire cta_byte_t opa_w = (dir_dest_w || mem_dest_w) ? req_q.src : req_q.acc;
   wire cta_byte_t opb_w = imm_src_w ? req_q.imm : (acc_src_w ? req_q.acc : req_q.src);
   wire logic wr_mem_w = dir_dest_w || mem_dest_w || ((mov_w || movx_w) && req_q.to_mem);
   wire logic wr_b_w = (op_w == CTA_OP_MUL) || (op_w == CTA_OP_DIV);

   // external-data target select
   wire cta_tgt_t tgt_w = req_q.flash_sel ? CTA_TGT_FLASH
      : ((req_q.addr <= CTA_EXPANSION_DATA_RAM_ONCHIP_TOP) ? CTA_TGT_ONCHIP : CTA_TGT_OFFCHIP);

   cta_byte_t alu_res_w;
   cta_byte_t alu_resb_w;
   cta_flags_t alu_flags_w;

   cta_alu u_alu (
      .op_i(op_w),
      .a_i(opa_w),
      .b_i(opb_w),
      .breg_i(req_q.b),
      .flags_i(req_q.flags),
      .res_o(alu_res_w),
      .resb_o(alu_resb_w),
      .flags_o(alu_flags_w)
   );

   // parity always tracks the accumulator as it stands after the operation
   wire cta_byte_t acc_after_w = wr_mem_w ? req_q.acc : alu_res_w;

   always_comb begin
      res_d = res_q;
      if (last_w) begin
         res_d.data = alu_res_w;
         res_d.b = alu_resb_w;
         res_d.wr_acc = !wr_mem_w;
         res_d.wr_mem = wr_mem_w;
         res_d.wr_b = wr_b_w;
         res_d.flags = alu_flags_w;
         res_d.flags.p = ^acc_after_w;
         res_d.tgt = tgt_w;
         res_d.bytes = cta_bytes(op_w, mode_w);
         res_d.cycles = cta_cycles(op_w, mode_w);
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         cnt_q <= CTA_CNT_ZERO;
         ready_q <= 1'b1;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
         busy_q <= (state_d == ST_EXEC);
         done_q <= last_w;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         req_q <= '0;
         res_q <= '0;
      end else begin
         if (accept_w) begin
            req_q <= req_i;
         end
         res_q <= res_d;
      end
   end

   // clocks spent by the instruction in flight, for checking only
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_q <= CTA_CNT_ZERO;
      end else if (accept_w) begin
         run_q <= CTA_CNT_STEP;
      end else if (step_w) begin
         run_q <= run_q + CTA_CNT_STEP;
      end
   end

   assign ready_o = ready_q;
   assign busy_o = busy_q;
   assign done_o = done_q;
   assign res_o = res_q;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);

   wire logic arith_w = (req_i.op == CTA_OP_ADD) || (req_i.op == CTA_OP_ADDC)
      || (req_i.op == CTA_OP_SUBB);
   wire logic logic_req_w = (req_i.op == CTA_OP_ANL) || (req_i.op == CTA_OP_ORL)
      || (req_i.op == CTA_OP_XRL);
   wire logic [8:0] chk_sum_w = {1'b0, req_i.acc} + {1'b0, req_i.src};

   chk_reg_single: assert property (
      accept_w && arith_w && req_i.mode == CTA_AM_REG
      |-> ##1 ready_o ##1 done_o && res_o.bytes == CTA_LEN_ONE && res_o.cycles == CTA_CYC_ONE)
      else $error("register-source arithmetic not one byte one cycle");

   chk_direct_pair: assert property (
      accept_w && arith_w && req_i.mode == CTA_AM_DIRECT
      |-> ##1 !ready_o ##1 ready_o ##1 done_o && res_o.bytes == CTA_LEN_TWO)
      else $error("direct-source arithmetic not two bytes two cycles");

   chk_indirect_pair: assert property (
      accept_w && arith_w && req_i.mode == CTA_AM_INDIRECT
      |-> ##2 !done_o ##1 done_o && res_o.bytes == CTA_LEN_ONE && res_o.cycles == CTA_CYC_TWO)
      else $error("indirect arithmetic not one byte two cycles");

   chk_imm_pair: assert property (
      accept_w && arith_w && req_i.mode == CTA_AM_IMM
      |-> ##3 done_o && res_o.bytes == CTA_LEN_TWO && res_o.cycles == CTA_CYC_TWO)
      else $error("immediate arithmetic not two bytes two cycles");

   chk_logic_triple: assert property (
      accept_w && logic_req_w && req_i.mode == CTA_AM_DIR_IMM
      |-> ##1 (!ready_o)[*2] ##1 ready_o ##1 done_o && res_o.wr_mem && res_o.bytes == CTA_LEN_THREE)
      else $error("immediate-to-direct logic not three bytes three cycles");

   chk_accop_single: assert property (
      accept_w && cta_acc_only(req_i.op)
      |-> ##2 done_o && res_o.wr_acc && res_o.cycles == CTA_CYC_ONE)
      else $error("accumulator operation not one cycle");

   chk_movdd_triple: assert property (
      accept_w && req_i.op == CTA_OP_MOV && req_i.mode == CTA_AM_DIR_DIR
      |-> ##4 done_o && res_o.bytes == CTA_LEN_THREE && res_o.data == $past(req_i.src, 4))
      else $error("direct-to-direct move wrong");

   chk_run_bound: assert property (
      run_q <= CTA_CYC_MAX)
      else $error("instruction ran longer than eight clocks");

   chk_div_eight: assert property (
      accept_w && req_i.op == CTA_OP_DIV |-> ##8 ready_o ##1 done_o && res_o.wr_b)
      else $error("divide not eight clocks");

   chk_mul_four: assert property (
      accept_w && req_i.op == CTA_OP_MUL
      |-> ##4 ready_o ##1 done_o && res_o.cycles == CTA_CYC_MUL && res_o.bytes == CTA_LEN_ONE)
      else $error("multiply not four clocks");

   chk_add_carry: assert property (
      accept_w && req_i.op == CTA_OP_ADD && req_i.mode == CTA_AM_REG
      |-> ##2 done_o && res_o.flags.cy == $past(chk_sum_w[8], 2) && res_o.data == $past(chk_sum_w[7:0], 2))
      else $error("add carry or sum wrong");

   chk_movx_target: assert property (
      accept_w && req_i.op == CTA_OP_MOVX && req_i.flash_sel
      |-> ##4 done_o && res_o.tgt == CTA_TGT_FLASH)
      else $error("flash-selected external move went elsewhere");

   chk_logic_dir_acc: assert property (
      accept_w && logic_req_w && req_i.mode == CTA_AM_DIR_ACC
      |-> ##3 done_o && res_o.wr_mem && res_o.bytes == CTA_LEN_TWO && res_o.cycles == CTA_CYC_TWO)
      else $error("accumulator-to-direct logic not two bytes two cycles");

   chk_load_indirect: assert property (
      accept_w && req_i.op == CTA_OP_MOV && req_i.mode == CTA_AM_INDIRECT && !req_i.to_mem
      |-> ##3 done_o && res_o.bytes == CTA_LEN_ONE && res_o.cycles == CTA_CYC_TWO
         && res_o.data == $past(req_i.src, 3))
      else $error("indirect load not one byte two cycles");

   chk_reg_move: assert property (
      accept_w && req_i.op == CTA_OP_MOV && req_i.mode == CTA_AM_REG
      |-> ##2 done_o && res_o.bytes == CTA_LEN_ONE && res_o.cycles == CTA_CYC_ONE)
      else $error("register move not one byte one cycle");
endmodule // cta_exec

`default_nettype wire

// *** verification/cta_exec_test.sv ***
// Purpose: self-checking bench for the cycle-timed alu datapath
// Assumes: cta_exec on one 50 MHz clock, async active-low reset
// Notes: inputs change 1 ns after each rising edge; expectations worked by hand
`timescale 1ns/100ps
`default_nettype none

module cta_exec_test;
   import cta_pkg::*;

   logic clock_i;
   logic rst_n_i;
   logic start;
   cta_req_t req;
   logic ready;
   logic busy;
   logic done;
   cta_res_t res;
   int err_total;
   int tests_run;

   cta_exec i_dut (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(start),
      .req_i(req),
      .ready_o(ready),
      .busy_o(busy),
      .done_o(done),
      .res_o(res)
   );

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t ns: %s got 0x%h expected 0x%h", $time, what, got, exp);
      end
   endtask

   task automatic set(input cta_op_t op, input cta_mode_t md, input cta_byte_t acc, input cta_byte_t src);
      req = '0;
      req.op = op;
      req.mode = md;
      req.acc = acc;
      req.src = src;
   endtask

   // issue one request, time it, check counts; returns 1 ns after the done edge
   task automatic run(input int n, input int len);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 20) begin
         @(posedge clock_i);
         #1;
         k++;
      end
      chk({15'h0, ready}, 16'h0001, "ready before start");
      if (k == 20) begin
         report_and_stop();
      end
      start = 1'b1;
      @(posedge clock_i);
      #1;
      start = 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 20) begin
         chk({15'h0, ready}, {15'h0, (k >= n - 1)}, "ready in flight");
         chk({15'h0, busy}, 16'h0001, "busy in flight");
         @(posedge clock_i);
         #1;
         k++;
      end
      chk(k[15:0], n[15:0], "latency");
      chk({12'h0, res.cycles}, n[15:0], "cycle count");
      chk({14'h0, res.bytes}, len[15:0], "byte count");
      if (k == 20) begin
         report_and_stop();
      end
   endtask

   task automatic t_reset();
      rst_n_i = 1'b0;
      repeat (5) @(posedge clock_i);
      #1;
      chk({13'h0, ready, busy, done}, 16'h0004, "reset outputs");
      chk({15'h0, res !== '0}, 16'h0000, "reset result");
      rst_n_i = 1'b1;
      $display("test reset finished");
   endtask

   task automatic t_arith();
      cta_op_t ops[3] = '{CTA_OP_ADD, CTA_OP_ADDC, CTA_OP_SUBB};
      cta_mode_t mds[4] = '{CTA_AM_REG, CTA_AM_DIRECT, CTA_AM_INDIRECT, CTA_AM_IMM};
      int ns[4] = '{1, 2, 2, 2};
      int ls[4] = '{1, 2, 1, 2};
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 4; j++) begin
            set(ops[i], mds[j], 8'h10, 8'h01);
            run(ns[j], ls[j]);
         end
      end
      set(CTA_OP_ADD, CTA_AM_REG, 8'h7F, 8'h01);
      run(1, 1);
      chk({8'h0, res.data}, 16'h0080, "add sum");
      chk({12'h0, res.flags}, 16'h0007, "add flags");
      set(CTA_OP_ADDC, CTA_AM_IMM, 8'hFF, 8'h55);
      req.flags.cy = 1'b1;
      run(2, 2);
      chk({8'h0, res.data}, 16'h0000, "addc sum");
      chk({12'h0, res.flags}, 16'h000C, "addc flags");
      set(CTA_OP_SUBB, CTA_AM_DIRECT, 8'h00, 8'h01);
      run(2, 2);
      chk({7'h0, res.wr_acc, res.data}, 16'h01FF, "subb difference");
      chk({12'h0, res.flags}, 16'h000C, "subb flags");
      set(CTA_OP_INC, CTA_AM_ACC, 8'hFF, 8'h00);
      run(1, 1);
      chk({6'h0, res.wr_acc, res.wr_mem, res.data}, 16'h0200, "inc acc");
      set(CTA_OP_DEC, CTA_AM_DIRECT, 8'h00, 8'h00);
      run(2, 2);
      chk({6'h0, res.wr_acc, res.wr_mem, res.data}, 16'h01FF, "dec direct");
      set(CTA_OP_DA, CTA_AM_ACC, 8'h9A, 8'h00);
      run(1, 1);
      chk({7'h0, res.flags.cy, res.data}, 16'h0100, "decimal adjust");
      $display("test arith finished");
   endtask

   task automatic t_logic();
      cta_op_t ops[3] = '{CTA_OP_ANL, CTA_OP_ORL, CTA_OP_XRL};
      cta_mode_t mds[6] = '{CTA_AM_REG, CTA_AM_INDIRECT, CTA_AM_DIRECT, CTA_AM_IMM, CTA_AM_DIR_ACC, CTA_AM_DIR_IMM};
      int ns[6] = '{1, 2, 2, 2, 2, 3};
      int ls[6] = '{1, 1, 2, 2, 2, 3};
      for (int i = 0; i < 3; i++) begin
         for (int j = 0; j < 6; j++) begin
            set(ops[i], mds[j], 8'hF0, 8'h3C);
            run(ns[j], ls[j]);
         end
      end
      set(CTA_OP_ANL, CTA_AM_DIRECT, 8'hF0, 8'h3C);
      run(2, 2);
      chk({6'h0, res.wr_acc, res.wr_mem, res.data}, 16'h0230, "and into acc");
      set(CTA_OP_ORL, CTA_AM_DIR_ACC, 8'h81, 8'h42);
      run(2, 2);
      chk({6'h0, res.wr_acc, res.wr_mem, res.data}, 16'h01C3, "or into direct");
      set(CTA_OP_XRL, CTA_AM_DIR_IMM, 8'hAA, 8'h0F);
      req.imm = 8'hFF;
      run(3, 3);
      chk({6'h0, res.wr_acc, res.wr_mem, res.data}, 16'h01F0, "xor imm into direct");
      $display("test logic finished");
   endtask

   task automatic t_acc();
      cta_op_t ops[8] = '{CTA_OP_CLR, CTA_OP_CPL, CTA_OP_RL, CTA_OP_RLC, CTA_OP_RR, CTA_OP_RRC, CTA_OP_SWAP, CTA_OP_DA};
      logic [7:0] exp[8] = '{8'h00, 8'h7E, 8'h03, 8'h02, 8'hC0, 8'h40, 8'h18, 8'h81};
      for (int i = 0; i < 8; i++) begin
         set(ops[i], CTA_AM_ACC, 8'h81, 8'h00);
         run(1, 1);
         chk({8'h0, res.data}, {8'h0, exp[i]}, "acc op result");
         if (ops[i] == CTA_OP_RLC || ops[i] == CTA_OP_RRC) begin
            chk({15'h0, res.flags.cy}, 16'h0001, "rotate carry");
         end
      end
      $display("test acc finished");
   endtask

   task automatic t_move();
      cta_mode_t mds[8] = '{CTA_AM_REG, CTA_AM_REG, CTA_AM_DIRECT, CTA_AM_DIRECT,
                            CTA_AM_IMM, CTA_AM_DIR_ACC, CTA_AM_DIR_DIR, CTA_AM_INDIRECT};
      logic tm[8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      int ns[8] = '{1, 1, 2, 2, 2, 2, 3, 2};
      int ls[8] = '{1, 1, 2, 2, 2, 2, 3, 1};
      logic [7:0] exp[8] = '{8'h22, 8'h11, 8'h22, 8'h22, 8'h33, 8'h11, 8'h22, 8'h22};
      for (int i = 0; i < 8; i++) begin
         set(CTA_OP_MOV, mds[i], 8'h11, 8'h22);
         req.imm = 8'h33;
         req.to_mem = tm[i];
         run(ns[i], ls[i]);
         chk({6'h0, res.wr_acc, res.wr_mem, res.data}, {6'h0, ~tm[i], tm[i], exp[i]}, "move");
      end
      $display("test move finished");
   endtask

   task automatic t_muldiv();
      set(CTA_OP_MUL, CTA_AM_ACC, 8'h10, 8'h00);
      req.b = 8'h20;
      req.flags.cy = 1'b1;
      run(4, 1);
      chk({res.b, res.data}, 16'h0200, "product");
      chk({12'h0, res.flags}, 16'h0002, "mul flags");
      set(CTA_OP_DIV, CTA_AM_ACC, 8'h64, 8'h00);
      req.b = 8'h07;
      run(8, 1);
      chk({res.b, res.data}, 16'h020E, "quotient");
      chk({12'h0, res.flags}, 16'h0001, "div flags");
      set(CTA_OP_DIV, CTA_AM_ACC, 8'h55, 8'h00);
      run(8, 1);
      chk({res.b, res.data}, 16'h0055, "divide by zero");
      chk({12'h0, res.flags}, 16'h0002, "div zero flags");
      $display("test muldiv finished");
   endtask

   task automatic t_movx();
      logic fs[3] = '{1'b0, 1'b0, 1'b1};
      cta_addr_t ad[3] = '{16'h0FFF, 16'h1000, 16'h0000};
      cta_tgt_t tg[3] = '{CTA_TGT_ONCHIP, CTA_TGT_OFFCHIP, CTA_TGT_FLASH};
      for (int i = 0; i < 6; i++) begin
         set(CTA_OP_MOVX, CTA_AM_ACC, 8'h3C, 8'h99);
         req.flash_sel = fs[i % 3];
         req.addr = ad[i % 3];
         req.to_mem = (i >= 3);
         run(3, 1);
         chk({14'h0, res.tgt}, {14'h0, tg[i % 3]}, "move target");
         chk({8'h0, res.data}, (i >= 3) ? 16'h003C : 16'h0099, "external data");
      end
      $display("test movx finished");
   endtask

   // start held high: refused while ready low, taken again at cycle N
   task automatic t_b2b();
      logic [4:0] seen;
      set(CTA_OP_ADD, CTA_AM_DIRECT, 8'h01, 8'h01);
      start = 1'b1;
      for (int c = 0; c < 5; c++) begin
         @(posedge clock_i);
         #1;
         if (c == 0) begin
            set(CTA_OP_ADD, CTA_AM_DIRECT, 8'h02, 8'h02);
         end
         if (c == 2) begin
            start = 1'b0;
            chk({8'h0, res.data}, 16'h0002, "first of pair");
         end
         seen[c] = done;
      end
      chk({11'h0, seen}, 16'h0014, "done spacing");
      chk({8'h0, res.data}, 16'h0004, "second of pair");
      $display("test back to back finished");
   endtask

   task automatic t_reset_mid();
      set(CTA_OP_MUL, CTA_AM_ACC, 8'h03, 8'h00);
      req.b = 8'h05;
      start = 1'b1;
      @(posedge clock_i);
      #1;
      start = 1'b0;
      @(posedge clock_i);
      #1;
      rst_n_i = 1'b0;
      #1;
      chk({13'h0, ready, busy, done}, 16'h0004, "mid-run reset");
      @(posedge clock_i);
      #1;
      chk({15'h0, res !== '0}, 16'h0000, "result cleared");
      rst_n_i = 1'b1;
      set(CTA_OP_CPL, CTA_AM_ACC, 8'h0F, 8'h00);
      run(1, 1);
      chk({8'h0, res.data}, 16'h00F0, "after reset");
      $display("test mid reset finished");
   endtask

   initial begin
      err_total = 0;
      tests_run = 0;
      rst_n_i = 1'b0;
      start = 1'b0;
      req = '0;
      t_reset();
      t_arith();
      t_logic();
      t_acc();
      t_move();
      t_muldiv();
      t_movx();
      t_b2b();
      t_reset_mid();
      report_and_stop();
   end
endmodule // cta_exec_test

`default_nettype wire
